// ===== rtl/urph_pkg.sv
// urph_pkg: constants and carrier types for the received-packet header builder
// assumes one core clock; all users reference items as urph_pkg::name
package urph_pkg;

    // header layout, relative byte positions within a stored packet
    localparam int HDR_LEN = 8;
    localparam logic [2:0] OFS_EP_FLAGS = 3'h0;
    localparam logic [2:0] OFS_PID = 3'h1;
    localparam logic [2:0] OFS_ADDR = 3'h2;
    localparam logic [2:0] OFS_RSVD = 3'h3;
    localparam logic [2:0] OFS_FRAME_LO = 3'h4;
    localparam logic [2:0] OFS_FRAME_HI = 3'h5;
    localparam logic [2:0] OFS_COUNT_LO = 3'h6;
    localparam logic [2:0] OFS_COUNT_HI = 3'h7;
    localparam logic [2:0] OFS_LAST = 3'h7;
    localparam logic [11:0] OFS_PAYLOAD = 12'h008;

    // field positions inside header byte 0
    localparam int BIT_BAD_TOGGLE = 5;
    localparam int BIT_RX_TOGGLE = 6;
    localparam int BIT_BAD_CRC = 7;

    // widths and limits
    localparam int EP_W = 4;
    localparam int NUM_EP = 16;
    localparam int COUNT_W = 11;
    localparam int ADDR_W = 12;
    localparam logic [10:0] MAX_PAYLOAD = 11'h500;
    localparam logic [7:0] RSVD_VALUE = 8'h00;

    // reset values
    localparam logic [15:0] TOGGLE_RESET = 16'hFFFF;
    localparam logic [10:0] COUNT_RESET = 11'h000;

    // fields the serial engine presents at packet start
    typedef struct packed {
        logic [3:0] endpoint;
        logic [3:0] packetIdentifierField;
        logic [6:0] matchedFunctionAddress;
        logic [15:0] frameCount;
    } urph_start_t;

    // fields the serial engine presents at packet end
    typedef struct packed {
        logic receivedToggleValue;
        logic crcError;
    } urph_end_t;

    // write port into packet buffer memory
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] data;
        logic we;
    } urph_mem_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PAYLOAD,
        ST_HEADER
    } urph_state_t;

endpackage

// ===== rtl/urph_header_byte.sv
// urph_header_byte: selects one header byte by its relative position
// assumes purely combinational use by the header builder
`timescale 1ns/10ps
module urph_header_byte (
    input wire logic [2:0] index,
    input wire urph_pkg::urph_start_t info,
    input wire logic unexpectedToggleFlag,
    input wire logic receivedToggleValue,
    input wire logic crcError,
    input wire logic [10:0] byteCount,
    output logic [7:0] headerByte
);

    // byte layout of the eight-byte record
    always_comb begin
        headerByte = 8'h00;
        case (index)
            urph_pkg::OFS_EP_FLAGS: begin
                headerByte[3:0] = info.endpoint; // RL3
                headerByte[4] = 1'b0; // RL3
                headerByte[urph_pkg::BIT_BAD_TOGGLE] = unexpectedToggleFlag; // RL8
                headerByte[urph_pkg::BIT_RX_TOGGLE] = receivedToggleValue; // RL10
                headerByte[urph_pkg::BIT_BAD_CRC] = crcError; // RL11
            end
            urph_pkg::OFS_PID: begin
                headerByte = {4'h0, info.packetIdentifierField}; // RL2
            end
            urph_pkg::OFS_ADDR: begin
                headerByte = {1'b0, info.matchedFunctionAddress}; // RL2
            end
            urph_pkg::OFS_RSVD: begin
                headerByte = urph_pkg::RSVD_VALUE; // RL2
            end
            urph_pkg::OFS_FRAME_LO: begin
                headerByte = info.frameCount[7:0]; // RL6
            end
            urph_pkg::OFS_FRAME_HI: begin
                headerByte = info.frameCount[15:8]; // RL6
            end
            urph_pkg::OFS_COUNT_LO: begin
                headerByte = byteCount[7:0]; // RL4
            end
            urph_pkg::OFS_COUNT_HI: begin
                headerByte = {5'h00, byteCount[10:8]}; // RL4
            end
            default: begin
                headerByte = 8'h00;
            end
        endcase
    end

endmodule

// ===== rtl/urph_rx_header_builder.sv
// urph_rx_header_builder: stores one received packet as header plus payload
// assumes the serial engine drives start, bytes and end on ref_clk in that order
`timescale 1ns/10ps

// Function
// RL1 - every stored packet starts with an eight-byte header at positions 0..7
// RL2 - serial-engine part fills bytes 0..5: endpoint/flags, identifier, address, reserved
// RL3 - byte 0 low nibble is endpoint number, bit 4 is zero
// RL4 - buffer DMA part fills bytes 6..7 with the 11-bit byte count
// RL5 - byte count equals payload bytes stored; count minus one is last byte
// RL6 - bytes 4 and 5 carry the 16-bit frame count, low byte first
// RL7 - payload is stored contiguously from position 8 up to count plus 7
// RL8 - byte 0 bit 5 flags an unexpected data toggle
// RL9 - unexpected when previous and current toggle are equal
// RL10 - byte 0 bit 6 holds the toggle of the packet just received
// RL11 - byte 0 bit 7 set on CRC mismatch, clear otherwise
// RL12 - firmware routes each packet by the endpoint field of its header
// RL13 - payload lengths from zero up to 1280 bytes are supported
// RL14 - all eight header bytes are written before the packet is announced; packetDone rises in the same cycle as the byte 7 write
// RL15 - previous toggle is kept per endpoint for the comparison
module urph_rx_header_builder #(
    parameter logic [10:0] MAX_BYTES = urph_pkg::MAX_PAYLOAD
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic startValid,
    input wire urph_pkg::urph_start_t startInfo,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    output logic byteReady,
    input wire logic endValid,
    input wire urph_pkg::urph_end_t endInfo,
    output urph_pkg::urph_mem_t memWrite,
    output logic packetDone,
    output logic [10:0] packetByteCount,
    output logic packetOverflow,
    output logic busy
);

    typedef struct packed {
        urph_pkg::urph_state_t st;
        urph_pkg::urph_start_t info;
        logic unexpectedToggleFlag;
        logic receivedToggleValue;
        logic crcError;
        logic [10:0] count;
        logic overflow;
        logic [2:0] hdrIdx;
        logic [15:0] lastToggle;
        urph_pkg::urph_mem_t mem;
        logic done;
        logic [10:0] doneCount;
        logic doneOverflow;
    } urph_core_t;

    urph_core_t core_r;
    urph_core_t core_nxt;
    logic [7:0] hdrByte;
    logic prevToggle;

    // header byte for the current header position
    urph_header_byte hdrSel (
        .index(core_r.hdrIdx),
        .info(core_r.info),
        .unexpectedToggleFlag(core_r.unexpectedToggleFlag),
        .receivedToggleValue(core_r.receivedToggleValue),
        .crcError(core_r.crcError),
        .byteCount(core_r.count),
        .headerByte(hdrByte)
    );

    // previous toggle of the endpoint this packet belongs to
    assign prevToggle = core_r.lastToggle[core_r.info.endpoint]; // RL15

    // payload bytes are taken only between start and end
    assign byteReady = (core_r.st == urph_pkg::ST_PAYLOAD);
    assign busy = (core_r.st != urph_pkg::ST_IDLE);
    assign memWrite = core_r.mem;
    assign packetDone = core_r.done;
    assign packetByteCount = core_r.doneCount;
    assign packetOverflow = core_r.doneOverflow;

    // next-state logic for the whole builder
    always_comb begin
        core_nxt = core_r;
        core_nxt.mem.we = 1'b0;
        core_nxt.done = 1'b0;
        case (core_r.st)
            urph_pkg::ST_IDLE: begin
                if (startValid) begin
                    core_nxt.info = startInfo; // RL2
                    core_nxt.count = urph_pkg::COUNT_RESET;
                    core_nxt.overflow = 1'b0;
                    core_nxt.st = urph_pkg::ST_PAYLOAD;
                end
            end
            urph_pkg::ST_PAYLOAD: begin
                if (byteValid) begin
                    if (core_r.count < MAX_BYTES) begin
                        // payload lands behind the header, one byte per cycle
                        core_nxt.mem.addr = urph_pkg::OFS_PAYLOAD + {1'b0, core_r.count}; // RL7
                        core_nxt.mem.data = byteData;
                        core_nxt.mem.we = 1'b1;
                        core_nxt.count = core_r.count + 11'h001; // RL5 RL13
                    end else begin
                        core_nxt.overflow = 1'b1; // RL13
                    end
                end
                if (endValid) begin
                    core_nxt.receivedToggleValue = endInfo.receivedToggleValue; // RL10
                    core_nxt.crcError = endInfo.crcError; // RL11
                    core_nxt.unexpectedToggleFlag = (prevToggle == endInfo.receivedToggleValue); // RL9
                    if (!endInfo.crcError) begin
                        core_nxt.lastToggle[core_r.info.endpoint] = endInfo.receivedToggleValue; // RL15
                    end
                    core_nxt.hdrIdx = urph_pkg::OFS_EP_FLAGS;
                    core_nxt.st = urph_pkg::ST_HEADER;
                end
            end
            urph_pkg::ST_HEADER: begin
                // bytes 0..5 are the serial-engine part, 6..7 the DMA part
                core_nxt.mem.addr = {9'h000, core_r.hdrIdx}; // RL1
                core_nxt.mem.data = hdrByte; // RL2 RL4
                core_nxt.mem.we = 1'b1;
                core_nxt.hdrIdx = core_r.hdrIdx + 3'h1;
                if (core_r.hdrIdx == urph_pkg::OFS_LAST) begin
                    core_nxt.done = 1'b1; // RL14
                    core_nxt.doneCount = core_r.count; // RL5
                    core_nxt.doneOverflow = core_r.overflow;
                    core_nxt.st = urph_pkg::ST_IDLE;
                end
            end
            default: begin
                core_nxt.st = urph_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_r <= '0;
            core_r.st <= urph_pkg::ST_IDLE;
            core_r.lastToggle <= urph_pkg::TOGGLE_RESET;
        end else begin
            core_r <= core_nxt;
        end
    end

endmodule

// ===== sim/urph_asserts.sv
// urph_asserts: port-level timing and field checks on the header builder
// assumes it is bound into every urph_rx_header_builder instance
`timescale 1ns/10ps
module urph_asserts #(
    parameter logic [10:0] MAX_BYTES = urph_pkg::MAX_PAYLOAD
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    input wire logic byteReady,
    input wire logic endValid,
    input wire urph_pkg::urph_mem_t memWrite,
    input wire logic packetDone,
    input wire logic [10:0] packetByteCount,
    input wire logic busy
);
    logic [10:0] accCnt_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // payload bytes accepted so far in the current packet, held at the cap
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            accCnt_r <= 11'h000;
        end else if (!byteReady) begin
            accCnt_r <= 11'h000;
        end else if (byteValid && accCnt_r < MAX_BYTES) begin
            accCnt_r <= accCnt_r + 11'h001;
        end
    end
    // payload and header write timing
    AST_BYTE_WR: assert property (byteValid && byteReady && accCnt_r < MAX_BYTES |=> memWrite.we
        && memWrite.data == $past(byteData) && memWrite.addr == urph_pkg::OFS_PAYLOAD + {1'b0, $past(accCnt_r)})
        else $error("payload byte not written");
    AST_BYTE_DROP: assert property (byteValid && byteReady && accCnt_r == MAX_BYTES |=> !memWrite.we)
        else $error("byte beyond cap written");
    AST_HDR_FIRST: assert property (endValid && byteReady |-> ##2 memWrite.we && memWrite.addr == 12'h000)
        else $error("header not started");
    AST_DONE_AT8: assert property (endValid && byteReady |-> ##9 packetDone && memWrite.addr == 12'h007)
        else $error("done not after last header byte");
    AST_DONE_PULSE: assert property (packetDone |-> !busy ##1 !packetDone)
        else $error("done not one cycle");
    // fixed zero fields, the byte count and no activity while idle
    AST_BIT4_ZERO: assert property (memWrite.we && memWrite.addr == 12'h000 |-> !memWrite.data[4])
        else $error("byte0 bit4 set");
    AST_PID_HI: assert property (memWrite.we && memWrite.addr == 12'h001 |-> memWrite.data[7:4] == 4'h0)
        else $error("pid upper nibble set");
    AST_RSVD: assert property (memWrite.we && memWrite.addr == 12'h003 |-> memWrite.data == 8'h00)
        else $error("reserved byte not zero");
    AST_COUNT: assert property (packetDone |-> memWrite.data == {5'h00, packetByteCount[10:8]}
        && $past(memWrite.data) == packetByteCount[7:0])
        else $error("count bytes wrong");
    AST_IDLE: assert property (!busy && !packetDone |-> !byteReady && !memWrite.we)
        else $error("activity while idle");
endmodule
bind urph_rx_header_builder urph_asserts #(.MAX_BYTES(MAX_BYTES)) chk (.ref_clk(ref_clk), .rst(rst), .byteValid(byteValid),
    .byteData(byteData), .byteReady(byteReady), .endValid(endValid), .memWrite(memWrite),
    .packetDone(packetDone), .packetByteCount(packetByteCount), .busy(busy));

// ===== sim/urph_fw_model.sv
// urph_fw_model: firmware view of packet buffer memory
// assumes one packet record at relative address 0 at a time
`timescale 1ns/10ps
module urph_fw_model (
    input wire logic ref_clk,
    input wire urph_pkg::urph_mem_t memWrite
);
    logic [7:0] mem [0:4095];
    // capture every buffer write; records are read only after packetDone
    always @(posedge ref_clk) begin
        if (memWrite.we) begin
            mem[memWrite.addr] <= memWrite.data;
        end
    end
endmodule

// ===== sim/urph_rx_header_builder_tb.sv
// urph_rx_header_builder_tb: random packets compared with a queue model
// assumes MAX_BYTES set to 16 so the cap is reached in short packets
`timescale 1ns/10ps
module urph_rx_header_builder_tb;
    localparam int MAXB = 16;
    logic ref_clk = 0, rst = 1, startValid = 0, byteValid = 0, endValid = 0;
    logic byteReady, packetDone, packetOverflow, busy;
    logic [7:0] byteData = 8'h00;
    logic [10:0] packetByteCount;
    urph_pkg::urph_start_t startInfo = '0;
    urph_pkg::urph_end_t endInfo = '0;
    urph_pkg::urph_mem_t memWrite;
    int n_fail = 0, tests_run = 0, seed = 45209;
    bit hung = 0;
    bit prevTog [16] = '{default: 1};
    byte unsigned pay [$];
    always #4 ref_clk = ~ref_clk;
    urph_rx_header_builder #(.MAX_BYTES(11'h010)) uut (.ref_clk(ref_clk), .rst(rst), .startValid(startValid),
        .startInfo(startInfo), .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady),
        .endValid(endValid), .endInfo(endInfo), .memWrite(memWrite), .packetDone(packetDone),
        .packetByteCount(packetByteCount), .packetOverflow(packetOverflow), .busy(busy));
    urph_fw_model fw (.ref_clk(ref_clk), .memWrite(memWrite));
    // compare and count
    task check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one packet with stalls and a refused start, then read back the record
    task send(int len, logic [3:0] ep, bit tog, bit crc);
        int k, w, cnt;
        urph_pkg::urph_start_t si;
        si = $random(seed);
        si.endpoint = ep;
        pay.delete();
        for (k = 0; k < 32; k++) fw.mem[k] = ~k[7:0];
        @(negedge ref_clk);
        startValid = 1;
        startInfo = si;
        k = 0;
        while (k < len) begin
            @(negedge ref_clk);
            startInfo = $random(seed);
            byteValid = $random(seed);
            byteData = $random(seed);
            if (byteValid) begin
                pay.push_back(byteData);
                k++;
            end
        end
        @(negedge ref_clk);
        {startValid, byteValid, endValid} = 3'h1;
        endInfo = {tog, crc};
        @(negedge ref_clk);
        endValid = 0;
        w = 0;
        while (!packetDone && w < 20) begin
            @(posedge ref_clk);
            #1 w++;
        end
        if (w == 20) begin
            n_fail++;
            hung = 1;
            return;
        end
        cnt = len > MAXB ? MAXB : len;
        check("cnt", packetByteCount, cnt);
        check("ovf", packetOverflow, len > MAXB);
        @(posedge ref_clk);
        #1 check("busy", busy, 0);
        check("hdr0", fw.mem[0], {crc, tog, prevTog[ep] == tog, 1'b0, ep});
        check("hdr1", fw.mem[1], si.packetIdentifierField);
        check("hdr2", fw.mem[2], si.matchedFunctionAddress);
        check("hdr3", fw.mem[3], 0);
        check("frame", {fw.mem[5], fw.mem[4]}, si.frameCount);
        check("count", {fw.mem[7], fw.mem[6]}, cnt);
        for (k = 0; k < cnt; k++) check("pay", fw.mem[8 + k], pay[k]);
        if (!crc) prevTog[ep] = tog;
    endtask
    // two runs of packets with a reset between them
    initial begin
        int lens [6] = '{0, 1, 2, 15, 16, 18};
        repeat (2) begin
            repeat (4) @(negedge ref_clk);
            rst = 0;
            prevTog = '{default: 1};
            for (int i = 0; i < 30 && !hung; i++) send(lens[i % 6], i % 5, $random(seed), ($random(seed) & 3) == 0);
            @(negedge ref_clk);
            rst = 1;
        end
        report_and_stop();
    end
endmodule
